// File: shared/adc_regs_pkg.sv
package adc_regs_pkg;

  // ----------------------------------------
  // Register addresses on the serial port
  // ----------------------------------------
  localparam logic [7:0] ADDR_OFFSET_HIGH = 8'h03;
  localparam logic [7:0] ADDR_OFFSET_TRIM_LOW = 8'h04;
  localparam logic [7:0] ADDR_MAIN_MODE_CONTROL = 8'h05;
  localparam logic [7:0] ADDR_OUTPUT_DRIVER_PATTERN_CONTROL = 8'h06;
  localparam logic [7:0] ADDR_DIE_TEMPERATURE_READOUT = 8'h08;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] MAIN_MODE_RESET = 8'h20;
  localparam logic [7:0] OUTPUT_CTRL_RESET = 8'h04;

  // ----------------------------------------
  // Main mode field positions
  // ----------------------------------------
  localparam int MODE_STAGGER_BIT = 1;
  localparam int MODE_EXT_REF_BIT = 2;
  localparam int MODE_TWOS_COMP_BIT = 3;
  localparam int MODE_SYNC_BIT = 4;
  localparam int MODE_SLEEP_BIT = 6;
  localparam int MODE_TEMP_EN_BIT = 7;

  // ----------------------------------------
  // Output control field positions and codes
  // ----------------------------------------
  localparam int OUT_FORCE_LSB = 0;
  localparam int OUT_CURRENT_LSB = 2;
  localparam int OUT_TERM_LSB = 4;
  localparam int OUT_MODE_LSB = 6;
  localparam logic [1:0] FORCE_LOW = 2'h2;
  localparam logic [1:0] FORCE_HIGH = 2'h3;
  localparam logic [1:0] OMODE_NORMAL = 2'h0;
  localparam logic [1:0] OMODE_SCRAMBLE = 2'h1;
  localparam logic [1:0] OMODE_PRBS = 2'h2;
  localparam logic [1:0] OMODE_TOGGLE = 2'h3;

  // ----------------------------------------
  // Datapath and PRBS
  // ----------------------------------------
  localparam int SAMPLE_WIDTH = 12;
  localparam logic [6:0] PRBS_SEED = 7'h7F;

endpackage

// File: hw/bit_sync.sv
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  // Clock and control
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage1_next;
  logic [WIDTH-1:0] stage2_next;

  // Two flops; first stage feeds only the second
  always_comb begin
    stage1_next = clk_en ? async_in : stage1_reg;
    stage2_next = clk_en ? stage1_reg : stage2_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign sync_out = stage2_reg;

endmodule

// File: hw/prbs7_gen.sv
`timescale 1ns/1ps
module prbs7_gen (
  // Clock and control
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic advance,
  // Pattern
  output logic [6:0] state
);

  logic [6:0] lfsr_reg;
  logic [6:0] lfsr_next;

  // x^7 + x^6 + 1, one step per output word
  always_comb begin
    lfsr_next = lfsr_reg;
    if (clk_en && advance) begin
      lfsr_next = {lfsr_reg[5:0], lfsr_reg[6] ^ lfsr_reg[5]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lfsr_reg <= adc_regs_pkg::PRBS_SEED;
    end else begin
      lfsr_reg <= lfsr_next;
    end
  end

  assign state = lfsr_reg;

endmodule

// File: hw/adc_output_config_regs.sv
`timescale 1ns/1ps
// Function
// - offset low byte joins bit eight
// - code zero most negative, all-ones most positive
// - offset resets to zero, then takes factory strap value
// - mode bit one staggers bus B
// - mode bit three selects two's complement
// - mode bit four puts sync on overrange
// - mode bit six enters sleep
// - mode bit seven keeps sensor active
// - force field drives both buses and clk_out low or high, not the overrange flags
// - current field selects drive, resets 01
// - termination field 10 200, 11 100 ohm
// - mode 00 passes samples unchanged
// - mode 01 xors upper bits with bit0
// - mode 10 substitutes PRBS7 pattern
// - mode 11 toggles all ones, zeros
// - temperature register is read-only
module adc_output_config_regs #(
  parameter int SAMPLE_W = adc_regs_pkg::SAMPLE_WIDTH
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // Factory trim strap, caught after reset
  input wire logic [8:0] factory_offset,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Converter side
  input wire logic link_clk,
  input wire logic [SAMPLE_W-1:0] sample_a,
  input wire logic [SAMPLE_W-1:0] sample_b,
  input wire logic overrange_a,
  input wire logic overrange_b,
  input wire logic sync_marker,
  input wire logic [7:0] temp_sensor,
  // Output buses
  output logic [SAMPLE_W-1:0] bus_a,
  output logic [SAMPLE_W-1:0] bus_b,
  output logic overrange_flag_pin_a,
  output logic overrange_flag_pin_b,
  output logic clk_out,
  // Analog controls
  output logic [8:0] offset_code,
  output logic ext_ref_en,
  output logic sleep_mode,
  output logic temp_sensor_en,
  output logic [1:0] drive_current,
  output logic [1:0] term_select
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [8:0] offset_reg;
  logic [8:0] offset_next;
  logic strap_done_reg;
  logic strap_done_next;
  logic [7:0] mode_reg;
  logic [7:0] mode_next;
  logic [7:0] outctl_reg;
  logic [7:0] outctl_next;
  logic [7:0] temp_reg;
  logic [7:0] temp_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  logic [1:0] force_f;
  logic [1:0] omode_f;
  assign force_f = outctl_reg[adc_regs_pkg::OUT_FORCE_LSB +: 2];
  assign omode_f = outctl_reg[adc_regs_pkg::OUT_MODE_LSB +: 2];

  // ----------------------------------------
  // Register writes and reads
  // ----------------------------------------
  // Strap is caught one cycle after reset release, never under reset itself
  always_comb begin
    offset_next = offset_reg;
    strap_done_next = strap_done_reg;
    mode_next = mode_reg;
    outctl_next = outctl_reg;
    temp_next = temp_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    if (clk_en) begin
      if (!strap_done_reg) begin
        offset_next = factory_offset;
        strap_done_next = 1'b1;
      end
      // Sensor only updates while enabled; otherwise holds last reading
      if (temp_sensor_en) begin
        temp_next = temp_sensor;
      end
      if (reg_wr) begin
        case (reg_addr)
          adc_regs_pkg::ADDR_OFFSET_HIGH: offset_next[8] = reg_wdata[0];
          adc_regs_pkg::ADDR_OFFSET_TRIM_LOW: offset_next[7:0] = reg_wdata;
          adc_regs_pkg::ADDR_MAIN_MODE_CONTROL: mode_next = reg_wdata;
          adc_regs_pkg::ADDR_OUTPUT_DRIVER_PATTERN_CONTROL: outctl_next = reg_wdata;
          default: ; // Temperature and others ignore writes
        endcase
      end
      if (reg_rd) begin
        rvalid_next = 1'b1;
        case (reg_addr)
          adc_regs_pkg::ADDR_OFFSET_HIGH: rdata_next = {7'h00, offset_reg[8]};
          adc_regs_pkg::ADDR_OFFSET_TRIM_LOW: rdata_next = offset_reg[7:0];
          adc_regs_pkg::ADDR_MAIN_MODE_CONTROL: rdata_next = mode_reg;
          adc_regs_pkg::ADDR_OUTPUT_DRIVER_PATTERN_CONTROL: rdata_next = outctl_reg;
          adc_regs_pkg::ADDR_DIE_TEMPERATURE_READOUT: rdata_next = temp_reg;
          default: rdata_next = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      offset_reg <= 9'h000;
      strap_done_reg <= 1'b0;
      mode_reg <= adc_regs_pkg::MAIN_MODE_RESET;
      outctl_reg <= adc_regs_pkg::OUTPUT_CTRL_RESET;
      temp_reg <= 8'h00;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      offset_reg <= offset_next;
      strap_done_reg <= strap_done_next;
      mode_reg <= mode_next;
      outctl_reg <= outctl_next;
      temp_reg <= temp_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // ----------------------------------------
  // Link clock sampling
  // ----------------------------------------
  logic link_clk_sync;
  logic link_prev_reg;
  logic link_prev_next;
  logic word_tick;

  bit_sync #(.WIDTH(1)) u_link_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .async_in(link_clk),
    .sync_out(link_clk_sync)
  );

  // Edge found on the synchronised copy only
  always_comb begin
    link_prev_next = clk_en ? link_clk_sync : link_prev_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link_prev_reg <= 1'b0;
    end else begin
      link_prev_reg <= link_prev_next;
    end
  end

  assign word_tick = clk_en & link_clk_sync & ~link_prev_reg;

  // ----------------------------------------
  // Pattern sources
  // ----------------------------------------
  logic [6:0] prbs_state;
  logic toggle_reg;
  logic toggle_next;

  prbs7_gen u_prbs (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .advance(word_tick),
    .state(prbs_state)
  );

  // Toggle flips once per word
  always_comb begin
    toggle_next = word_tick ? ~toggle_reg : toggle_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      toggle_reg <= 1'b0;
    end else begin
      toggle_reg <= toggle_next;
    end
  end

  // ----------------------------------------
  // Output word shaping
  // ----------------------------------------
  // Samples arrive as offset binary; MSB flip gives two's complement
  function automatic logic [SAMPLE_W-1:0] shape(input logic [SAMPLE_W-1:0] raw, input logic [1:0] om,
                                                 input logic twos, input logic tog, input logic [6:0] prbs,
                                                 input logic [1:0] frc);
    logic [SAMPLE_W-1:0] w;
    logic [7*((SAMPLE_W+6)/7)-1:0] rep;
    w = raw;
    // Seven-bit state repeated wide enough, then cut to the word
    rep = {((SAMPLE_W+6)/7){prbs}};
    if (twos) begin
      w[SAMPLE_W-1] = ~raw[SAMPLE_W-1];
    end
    case (om)
      adc_regs_pkg::OMODE_NORMAL: ;
      adc_regs_pkg::OMODE_SCRAMBLE: w[SAMPLE_W-1:1] = w[SAMPLE_W-1:1] ^ {(SAMPLE_W-1){w[0]}};
      adc_regs_pkg::OMODE_PRBS: w = rep[SAMPLE_W-1:0];
      adc_regs_pkg::OMODE_TOGGLE: w = {SAMPLE_W{tog}};
      default: ;
    endcase
    // Forced levels checked last so they override
    if (frc == adc_regs_pkg::FORCE_LOW) begin
      w = '0;
    end else if (frc == adc_regs_pkg::FORCE_HIGH) begin
      w = '1;
    end
    return w;
  endfunction

  logic [SAMPLE_W-1:0] bus_a_reg;
  logic [SAMPLE_W-1:0] bus_a_next;
  logic [SAMPLE_W-1:0] bus_b_reg;
  logic [SAMPLE_W-1:0] bus_b_next;
  logic [SAMPLE_W-1:0] b_hold_reg;
  logic [SAMPLE_W-1:0] b_hold_next;
  logic ovr_a_reg;
  logic ovr_a_next;
  logic ovr_b_reg;
  logic ovr_b_next;
  logic clk_out_reg;
  logic clk_out_next;
  logic [SAMPLE_W-1:0] word_a;
  logic [SAMPLE_W-1:0] word_b;
  logic flag_a;
  logic flag_b;

  // Output words update on each link word; sleep freezes the data path, except that forced levels still apply
  always_comb begin
    word_a = shape(sample_a, omode_f, mode_reg[adc_regs_pkg::MODE_TWOS_COMP_BIT], toggle_reg, prbs_state,
                   force_f);
    word_b = shape(sample_b, omode_f, mode_reg[adc_regs_pkg::MODE_TWOS_COMP_BIT], toggle_reg, prbs_state,
                   force_f);
    flag_a = mode_reg[adc_regs_pkg::MODE_SYNC_BIT] ? sync_marker : overrange_a;
    flag_b = mode_reg[adc_regs_pkg::MODE_SYNC_BIT] ? sync_marker : overrange_b;
    bus_a_next = bus_a_reg;
    bus_b_next = bus_b_reg;
    b_hold_next = b_hold_reg;
    ovr_a_next = ovr_a_reg;
    ovr_b_next = ovr_b_reg;
    clk_out_next = clk_out_reg;
    if (clk_en && !sleep_mode) begin
      if (word_tick) begin
        bus_a_next = word_a;
        ovr_a_next = flag_a;
        ovr_b_next = flag_b;
        b_hold_next = word_b;
        // Stagger: bus B lags by half a word period
        bus_b_next = mode_reg[adc_regs_pkg::MODE_STAGGER_BIT] ? bus_b_reg : word_b;
      end else if (clk_en && link_prev_reg && !link_clk_sync &&
                   mode_reg[adc_regs_pkg::MODE_STAGGER_BIT]) begin
        bus_b_next = b_hold_reg;
      end
      clk_out_next = link_clk_sync;
    end
    // Force hits clock and buses at once, so a level check needs no word clock
    if (clk_en && force_f == adc_regs_pkg::FORCE_LOW) begin
      clk_out_next = 1'b0;
      bus_a_next = '0;
      bus_b_next = '0;
    end else if (clk_en && force_f == adc_regs_pkg::FORCE_HIGH) begin
      clk_out_next = 1'b1;
      bus_a_next = '1;
      bus_b_next = '1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_a_reg <= '0;
      bus_b_reg <= '0;
      b_hold_reg <= '0;
      ovr_a_reg <= 1'b0;
      ovr_b_reg <= 1'b0;
      clk_out_reg <= 1'b0;
    end else begin
      bus_a_reg <= bus_a_next;
      bus_b_reg <= bus_b_next;
      b_hold_reg <= b_hold_next;
      ovr_a_reg <= ovr_a_next;
      ovr_b_reg <= ovr_b_next;
      clk_out_reg <= clk_out_next;
    end
  end

  // ----------------------------------------
  // Outputs, all from flops
  // ----------------------------------------
  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign bus_a = bus_a_reg;
  assign bus_b = bus_b_reg;
  assign overrange_flag_pin_a = ovr_a_reg;
  assign overrange_flag_pin_b = ovr_b_reg;
  assign clk_out = clk_out_reg;
  assign offset_code = offset_reg;
  assign ext_ref_en = mode_reg[adc_regs_pkg::MODE_EXT_REF_BIT];
  assign sleep_mode = mode_reg[adc_regs_pkg::MODE_SLEEP_BIT];
  assign temp_sensor_en = mode_reg[adc_regs_pkg::MODE_TEMP_EN_BIT];
  assign drive_current = outctl_reg[adc_regs_pkg::OUT_CURRENT_LSB +: 2];
  assign term_select = outctl_reg[adc_regs_pkg::OUT_TERM_LSB +: 2];

endmodule

// File: verif/adc_output_config_regs_sva.sv
`timescale 1ns/1ps
module adc_cfg_checker #(
  parameter int SAMPLE_W = 12
) (
  // Clock and control
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rvalid,
  // Outputs watched
  input wire logic [SAMPLE_W-1:0] bus_a,
  input wire logic [SAMPLE_W-1:0] bus_b,
  input wire logic clk_out,
  input wire logic [8:0] offset_code,
  input wire logic sleep_mode,
  input wire logic temp_sensor_en,
  input wire logic [1:0] drive_current,
  input wire logic [1:0] term_select
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [7:0] mode_sh, outc_sh, mode_q, outc_q;
  logic [SAMPLE_W-1:0] prev_a;
  logic [1:0] prev_m;
  logic clk_q, word, ok, wr_en;
  assign word = clk_out && !clk_q;
  // Settings one cycle old are the ones the word was shaped with
  assign ok = !mode_q[6] && !outc_q[1];
  assign wr_en = reg_wr && clk_en;
  // Shadow of the mode registers; previous word kept for pattern steps
  always_ff @(posedge clk_sys) begin
    clk_q <= clk_out;
    mode_q <= mode_sh;
    outc_q <= outc_sh;
    if (rst) begin
      mode_sh <= 8'h20;
      outc_sh <= 8'h04;
      prev_m <= 2'h0;
    end else begin
      if (wr_en && reg_addr == 8'h05) mode_sh <= reg_wdata;
      if (wr_en && reg_addr == 8'h06) outc_sh <= reg_wdata;
      if (word) prev_a <= bus_a;
      if (word) prev_m <= ok ? outc_q[7:6] : 2'h0;
    end
  end
  rvalid_after_a: assert property (reg_rd && clk_en |=> reg_rvalid)
    else $error("read not answered next cycle");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd && clk_en))
    else $error("read answer without a read");
  drive_write_a: assert property (wr_en && reg_addr == 8'h06 |=>
    drive_current == $past(reg_wdata[3:2]) && term_select == $past(reg_wdata[5:4]))
    else $error("current or termination field not applied");
  mode_write_a: assert property (wr_en && reg_addr == 8'h05 |=>
    sleep_mode == $past(reg_wdata[6]) && temp_sensor_en == $past(reg_wdata[7]))
    else $error("sleep or sensor bit not applied");
  offset_low_a: assert property (wr_en && reg_addr == 8'h04 |=> offset_code[7:0] == $past(reg_wdata))
    else $error("offset low byte not applied");
  reset_vals_a: assert property ($fell(rst) |-> drive_current == 2'h1 && term_select == 2'h0 && !sleep_mode)
    else $error("output controls wrong after reset");
  force_low_a: assert property (outc_sh[1:0] == 2'h2 [*3] |-> bus_a == '0 && bus_b == '0 && !clk_out)
    else $error("outputs not forced low");
  force_high_a: assert property (outc_sh[1:0] == 2'h3 [*3] |-> &bus_a && &bus_b && clk_out)
    else $error("outputs not forced high");
  sleep_hold_a: assert property ((mode_sh[6] && !outc_sh[1]) [*3] |-> $stable(bus_a) && $stable(bus_b))
    else $error("buses moved while asleep");
  prbs_step_a: assert property (word && ok && outc_q[7:6] == 2'h2 && prev_m == 2'h2 |->
    bus_a[6:0] == {prev_a[5:0], prev_a[6] ^ prev_a[5]} && bus_a[11:7] == bus_a[4:0])
    else $error("pattern word is not the next sequence step");
  toggle_step_a: assert property (word && ok && outc_q[7:6] == 2'h3 && prev_m == 2'h3 |-> bus_a == ~prev_a)
    else $error("toggle word did not invert");
  prbs_seen_c: cover property (word && ok && prev_m == 2'h2);
  toggle_seen_c: cover property (word && ok && prev_m == 2'h3);
  read_seen_c: cover property (reg_rvalid);
endmodule

// File: verif/adc_word_source.sv
`timescale 1ns/1ps
module adc_word_source (
  // Next word from the bench
  input wire logic [26:0] next_word,
  // Converter-side outputs
  output logic link_clk,
  output logic [11:0] sample_a,
  output logic [11:0] sample_b,
  output logic overrange_a,
  output logic overrange_b,
  output logic sync_marker
);
  // Word clock, phase unrelated to the system clock
  initial begin
    {sync_marker, overrange_b, overrange_a, sample_b, sample_a} = 27'h0000000;
    link_clk = 1'b0;
    forever #62.5 link_clk = ~link_clk;
  end
  // Launch on the fall so data is settled around the rise
  always @(negedge link_clk) begin
    {sync_marker, overrange_b, overrange_a, sample_b, sample_a} <= next_word;
  end
endmodule

// File: verif/test_adc_output_config_regs.sv
`timescale 1ns/1ps
module test_adc_output_config_regs;
  logic clk_sys = 1'b0, rst = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, check_en = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, temp_sensor = 8'h00, reg_rdata, mode_v, outc_v;
  logic [8:0] factory_offset = 9'h000, offset_code;
  logic [26:0] next_word = 27'h0000000;
  logic [11:0] sample_a, sample_b, bus_a, bus_b, frozen, prev_b;
  logic link_clk, overrange_a, overrange_b, sync_marker, reg_rvalid, clk_out, clk_q;
  logic overrange_flag_pin_a, overrange_flag_pin_b, ext_ref_en, sleep_mode, temp_sensor_en;
  logic [1:0] drive_current, term_select;
  logic [31:0] rng = 32'd49165;
  logic [15:0] cfg[5] = '{16'h2004, 16'h2044, 16'h2804, 16'h2844, 16'h3004};
  logic [7:0] rq[$];
  logic [25:0] wq[$];
  int n_fail = 0;
  int checks_done = 0;
  // ----------------------------------------
  // Design, source and checker
  // ----------------------------------------
  adc_output_config_regs dut (.clk_sys, .rst, .clk_en, .factory_offset, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid, .link_clk, .sample_a, .sample_b, .overrange_a, .overrange_b,
    .sync_marker, .temp_sensor, .bus_a, .bus_b, .overrange_flag_pin_a, .overrange_flag_pin_b, .clk_out,
    .offset_code, .ext_ref_en, .sleep_mode, .temp_sensor_en, .drive_current, .term_select);
  adc_word_source src (.next_word, .link_clk, .sample_a, .sample_b, .overrange_a, .overrange_b, .sync_marker);
  // ----------------------------------------
  // Clock, stimulus helpers
  // ----------------------------------------
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Fresh random word offered every cycle
  always @(negedge clk_sys) begin
    rng <= xs(rng);
    next_word <= rng[26:0];
  end
  // Expected shape of a word from the inputs and the settings
  function automatic logic [25:0] exp_word();
    logic [11:0] a, b;
    a = sample_a;
    b = sample_b;
    a[11] = a[11] ^ mode_v[3];
    b[11] = b[11] ^ mode_v[3];
    if (outc_v[7:6] == adc_regs_pkg::OMODE_SCRAMBLE) begin
      a[11:1] = a[11:1] ^ {11{a[0]}};
      b[11:1] = b[11:1] ^ {11{b[0]}};
    end
    return mode_v[4] ? {sync_marker, sync_marker, b, a} : {overrange_b, overrange_a, b, a};
  endfunction
  always @(posedge link_clk) begin
    if (check_en) wq.push_back(exp_word());
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Results taken against the oldest note as they appear
  always @(negedge clk_sys) begin
    clk_q <= clk_out;
    if (reg_rvalid === 1'b1 && rq.size() > 0) cmp(reg_rdata, rq.pop_front());
    if (clk_out === 1'b1 && clk_q === 1'b0 && wq.size() > 0)
      cmp({overrange_flag_pin_b, overrange_flag_pin_a, bus_b, bus_a}, wq.pop_front());
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    if (a == 8'h05) mode_v = d;
    if (a == 8'h06) outc_v = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  // Whole words pass, then the outputs settle
  task automatic words(input int n);
    repeat (n) @(posedge link_clk);
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Hang guard, well beyond the expected run
  initial begin
    #50us;
    n_fail++;
    conclude();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    mode_v = 8'h20;
    outc_v = 8'h04;
    factory_offset = rng[8:0];
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    rd(8'h05, 8'h20);
    rd(8'h06, 8'h04);
    rd(8'h04, factory_offset[7:0]);
    rd(8'h03, {7'h00, factory_offset[8]});
    cmp(offset_code, factory_offset);
    wr(8'h03, 8'h01);
    wr(8'h04, 8'hFF);
    cmp(offset_code, 9'h1FF);
    wr(8'h03, 8'h00);
    wr(8'h04, 8'h00);
    cmp(offset_code, 9'h000);
    // Writes with the enable low must leave nothing behind
    clk_en = 1'b0;
    wr(8'h06, 8'h3C);
    clk_en = 1'b1;
    outc_v = 8'h04;
    rd(8'h06, 8'h04);
    for (int i = 0; i < 4; i++) begin
      wr(8'h06, {2'h0, i[1:0], i[1:0], 2'h0});
      cmp(drive_current, i);
      cmp(term_select, i);
    end
    rd(8'h06, 8'h3C);
    temp_sensor = rng[7:0];
    wr(8'h05, 8'hA0);
    cmp(temp_sensor_en, 1);
    wr(8'h08, ~temp_sensor);
    rd(8'h08, temp_sensor);
    rd(8'h10, 8'h00);
    // Sleep freezes the buses, the sensor keeps reading
    wr(8'h05, 8'hE0);
    frozen = bus_a;
    temp_sensor = ~temp_sensor;
    words(3);
    cmp(bus_a, frozen);
    cmp(sleep_mode, 1);
    rd(8'h08, temp_sensor);
    wr(8'h05, 8'h20);
    cmp(sleep_mode, 0);
    // Forced levels win over a selected pattern
    wr(8'h06, 8'h86);
    words(1);
    cmp({clk_out, bus_a, bus_b}, 25'h0000000);
    wr(8'h06, 8'hC7);
    words(1);
    cmp({clk_out, bus_a, bus_b}, 25'h1FFFFFF);
    wr(8'h06, 8'h84);
    words(4);
    wr(8'h06, 8'hC4);
    words(3);
    // Inverted here, so the compare stays twelve bits wide
    frozen = ~bus_a;
    words(1);
    cmp(bus_a, frozen);
    // Staggered B shows the previous word until the word clock falls
    wr(8'h05, 8'h26);
    cmp(ext_ref_en, 1);
    wr(8'h06, 8'h04);
    words(2);
    @(posedge link_clk);
    prev_b = sample_b;
    @(posedge link_clk);
    frozen = sample_b;
    repeat (4) @(negedge clk_sys);
    cmp(bus_a, sample_a);
    cmp(bus_b, prev_b);
    @(negedge link_clk);
    repeat (4) @(negedge clk_sys);
    cmp(bus_b, frozen);
    foreach (cfg[k]) begin
      wr(8'h05, cfg[k][15:8]);
      wr(8'h06, cfg[k][7:0]);
      words(2);
      check_en = 1'b1;
      words(6);
      check_en = 1'b0;
      words(1);
    end
    conclude();
  end
endmodule
bind adc_output_config_regs adc_cfg_checker #(.SAMPLE_W(SAMPLE_W)) chk (.clk_sys, .rst, .clk_en, .reg_wr,
  .reg_rd, .reg_addr, .reg_wdata, .reg_rvalid, .bus_a, .bus_b, .clk_out, .offset_code, .sleep_mode,
  .temp_sensor_en, .drive_current, .term_select);
